// ### rtl/css_master.v
// Clock-synchronous serial master channel with an AHB-Lite register slave.
//
// Contract
// - Mode field 001b selects synchronous serial
// - Clock direction 0 makes clock internally
// - Rate register and count source set speed
// - Polarity 0: drive falling, sample rising
// - Bit order 1 shifts MSB first
// - Flow control disable kills both handshakes
// - Output type 0 drives push-pull
// - Transmit only while transmit enable set
// - Receive only while receive enable set
// - Read-only transmit buffer empty flag
// - Read-only transmit shift empty flag
// - Receive complete set on buffer load
// - Receive buffer returns data and overrun
// - Cause 0 requests on empty buffer
// - Continuous receive enable bit, resets zero
// - Inversion 0 passes data unchanged
// - Error output enable 0 drives nothing
// - Multi clock 0 uses first pin only
// - Special mode registers reset to zero
// - Priority level 000b disables interrupt
// - Request bit set by hardware, cleared 0
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`include "css_consts.vh"
module css_master (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire sdata_in,
  output reg sdata_out,
  output reg sdata_oe,
  output reg sclk_out,
  output reg sclk_oe,
  output reg sclk2_out,
  output reg sclk2_oe,
  input wire cts_n_in,
  output reg rts_n_out,
  output reg err_n_out,
  output reg err_oe,
  output reg tx_irq
);
  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] tx_buffer;
  reg [7:0] rx_buffer;
  reg [7:0] bit_rate_generator;
  reg [7:0] mode_reg;
  reg [7:0] ctl0;
  reg [7:0] uart2_xfer_control_1;
  reg [7:0] special_mode_1;
  reg [7:0] special_mode_2;
  reg [7:0] special_mode_3;
  reg [7:0] special_mode_4;
  reg [7:0] uart01_shared_control;
  reg [2:0] int_priority_level;
  reg intr_pending;
  reg tx_buffer_empty;
  reg rx_complete;
  reg overrun_flag;
  reg wr_pend;
  reg [3:0] wr_idx;
  // ----------------------------------------
  // Engine state
  // ----------------------------------------
  reg [1:0] state;
  reg [7:0] shreg;
  reg [2:0] bit_cnt;
  reg half;
  reg [4:0] pre_cnt;
  reg [7:0] brg_cnt;
  reg ck;
  reg dq;
  reg xfer_done;
  reg [7:0] rx_word;
  reg [2:0] din_s;
  reg rx_lvl;
  reg [2:0] cts_s;
  reg cts_lvl;
  reg [4:0] pre_div;
  reg [7:0] next_sh;
  reg [7:0] rd_mux;
  // ----------------------------------------
  // Field aliases
  // ----------------------------------------
  wire [2:0] serial_mode_field = mode_reg[`CSS_MD_SMD];
  wire clock_source_select = mode_reg[`CSS_MD_CLOCK_SOURCE_SELECT];
  wire io_polarity_invert = mode_reg[`CSS_MD_IO_POLARITY_INVERT];
  wire [1:0] count_source_select = ctl0[`CSS_C0_CNT];
  wire handshake_source_select = ctl0[`CSS_C0_HSS];
  wire flow_control_disable = ctl0[`CSS_C0_FCD];
  wire output_type_select = ctl0[`CSS_C0_OTS];
  wire clock_polarity_select = ctl0[`CSS_C0_CPOL];
  wire bit_order_select = ctl0[`CSS_C0_ORD];
  wire tx_enable = uart2_xfer_control_1[`CSS_C1_TE];
  wire rx_enable = uart2_xfer_control_1[`CSS_C1_RE];
  wire ch2_tx_int_cause = uart2_xfer_control_1[`CSS_C1_IRS];
  wire ch2_data_invert = uart2_xfer_control_1[`CSS_C1_INV];
  wire ch2_error_out_enable = uart2_xfer_control_1[`CSS_C1_ERE];
  wire clock_pin_choice = uart01_shared_control[`CSS_UC_PINSEL];
  wire multi_clock_output_select = uart01_shared_control[`CSS_UC_MULTI];
  // ----------------------------------------
  // Derived control
  // ----------------------------------------
  wire mode_ok = (serial_mode_field == `CSS_SMD_CSIO);
  wire active = mode_ok && !clock_source_select;
  wire idle_lvl = !clock_polarity_select;
  wire tx_shift_empty = (state == ST_IDLE);
  // The clear-to-send input only gates a start with handshakes on.
  wire cts_ok = flow_control_disable || handshake_source_select || !cts_lvl;
  // A start needs a full buffer, an idle shifter and an enabled channel.
  wire start = active && tx_enable && !tx_buffer_empty && cts_ok && tx_shift_empty;
  wire out_bit = bit_order_select ? shreg[7] : shreg[0];
  wire rx_bit = rx_lvl ^ ch2_data_invert ^ io_polarity_invert;
  // One half period of the transfer clock lasts (divider + 1) * (rate + 1) clocks.
  wire pre_tick = (pre_cnt == pre_div);
  wire htick = pre_tick && (brg_cnt == bit_rate_generator);
  wire acc = hsel && htrans[`CSS_HTRANS_NS] && hready;
  wire rd_rxb = acc && !hwrite && (haddr[`CSS_IDX] == `CSS_A_RXB);
  wire wr_hit = wr_pend;
  always @* begin
    case (count_source_select)
      `CSS_SRC_F1: pre_div = `CSS_DIV_F1;
      `CSS_SRC_F8: pre_div = `CSS_DIV_F8;
      default: pre_div = `CSS_DIV_F32;
    endcase
  end
  always @* begin
    if (bit_order_select) begin
      next_sh = {shreg[6:0], rx_bit};
    end else begin
      next_sh = {rx_bit, shreg[7:1]};
    end
  end
  always @* begin
    case (haddr[`CSS_IDX])
      `CSS_A_RXB: rd_mux = rx_buffer;
      `CSS_A_BRG: rd_mux = bit_rate_generator;
      `CSS_A_MODE: rd_mux = mode_reg;
      `CSS_A_CTL0: begin
        rd_mux = ctl0;
        rd_mux[`CSS_C0_TXSE] = tx_shift_empty;
      end
      `CSS_A_CTL1: begin
        rd_mux = uart2_xfer_control_1;
        rd_mux[`CSS_C1_TBE] = tx_buffer_empty;
        rd_mux[`CSS_C1_RC] = rx_complete;
      end
      `CSS_A_SM1: rd_mux = special_mode_1;
      `CSS_A_SM2: rd_mux = special_mode_2;
      `CSS_A_SM3: rd_mux = special_mode_3;
      `CSS_A_SM4: rd_mux = special_mode_4;
      `CSS_A_UART01_SHARED_CONTROL: rd_mux = uart01_shared_control;
      `CSS_A_TIC: begin
        rd_mux = `CSS_RST8;
        rd_mux[`CSS_TIC_LVL] = int_priority_level;
        rd_mux[`CSS_TIC_IR] = intr_pending;
      end
      default: rd_mux = `CSS_RST8;
    endcase
  end
  // ----------------------------------------
  // Bus slave and register file
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `CSS_RST32;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_idx <= `CSS_A_TXB;
      tx_buffer <= `CSS_RST8;
      rx_buffer <= `CSS_RST8;
      bit_rate_generator <= `CSS_RST8;
      mode_reg <= `CSS_RST8;
      ctl0 <= `CSS_RST_CTL0;
      uart2_xfer_control_1 <= `CSS_RST_CTL1;
      special_mode_1 <= `CSS_RST8;
      special_mode_2 <= `CSS_RST8;
      special_mode_3 <= `CSS_RST8;
      special_mode_4 <= `CSS_RST8;
      uart01_shared_control <= `CSS_RST8;
      int_priority_level <= `CSS_LVL_OFF;
      intr_pending <= 1'b0;
      tx_buffer_empty <= 1'b1;
      rx_complete <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      wr_pend <= acc && hwrite;
      if (acc) begin
        wr_idx <= haddr[`CSS_IDX];
      end
      // Read data stands only during the data phase and is zero otherwise.
      if (acc && !hwrite) begin
        hrdata <= {24'h000000, rd_mux};
        if (haddr[`CSS_IDX] == `CSS_A_RXB) begin
          hrdata[`CSS_RXB_OER] <= overrun_flag;
        end
      end else begin
        hrdata <= `CSS_RST32;
      end
      if (wr_hit) begin
        case (wr_idx)
          `CSS_A_BRG: bit_rate_generator <= hwdata[7:0];
          `CSS_A_MODE: mode_reg <= hwdata[7:0];
          `CSS_A_CTL0: ctl0 <= hwdata[7:0];
          `CSS_A_CTL1: uart2_xfer_control_1 <= hwdata[7:0];
          `CSS_A_SM1: special_mode_1 <= hwdata[7:0];
          `CSS_A_SM2: special_mode_2 <= hwdata[7:0];
          `CSS_A_SM3: special_mode_3 <= hwdata[7:0];
          `CSS_A_SM4: special_mode_4 <= hwdata[7:0];
          `CSS_A_UART01_SHARED_CONTROL: uart01_shared_control <= hwdata[7:0] & `CSS_UC_KEEP;
          `CSS_A_TIC: int_priority_level <= hwdata[`CSS_TIC_LVL];
          default: ;
        endcase
      end
      // A write to the transmit buffer refills it even if a start empties it now.
      if (wr_hit && wr_idx == `CSS_A_TXB) begin
        tx_buffer <= hwdata[7:0];
        tx_buffer_empty <= 1'b0;
      end else if (start) begin
        tx_buffer_empty <= 1'b1;
      end
      // Hardware set wins over a software clear of the request bit.
      if ((start && !ch2_tx_int_cause) || (xfer_done && ch2_tx_int_cause)) begin
        intr_pending <= 1'b1;
      end else if (wr_hit && wr_idx == `CSS_A_TIC && !hwdata[`CSS_TIC_IR]) begin
        intr_pending <= 1'b0;
      end
      if (xfer_done && rx_enable) begin
        rx_buffer <= rx_word;
        rx_complete <= 1'b1;
      end else if (rd_rxb) begin
        rx_complete <= 1'b0;
      end
      if (xfer_done && rx_enable && rx_complete && !rd_rxb) begin
        overrun_flag <= 1'b1;
      end else if (!rx_enable) begin
        overrun_flag <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Each pin passes three flops; a new level counts once the last two agree.
  // The received level trails the data pin by four clocks, the engine's edge by five, so a half period
  // of fewer than six clocks samples the previous bit.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_s <= `CSS_SYNC_LO;
      rx_lvl <= 1'b0;
      cts_s <= `CSS_SYNC_HI;
      cts_lvl <= 1'b1;
    end else begin
      din_s <= {din_s[1:0], sdata_in};
      cts_s <= {cts_s[1:0], cts_n_in};
      if (din_s[1] == din_s[2]) begin
        rx_lvl <= din_s[2];
      end
      if (cts_s[1] == cts_s[2]) begin
        cts_lvl <= cts_s[2];
      end
    end
  end
  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      shreg <= `CSS_RST8;
      bit_cnt <= `CSS_BIT_ZERO;
      half <= 1'b0;
      pre_cnt <= `CSS_CNT_ZERO;
      brg_cnt <= `CSS_BRG_ZERO;
      ck <= 1'b1;
      dq <= 1'b1;
      xfer_done <= 1'b0;
      rx_word <= `CSS_RST8;
    end else begin
      xfer_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          ck <= idle_lvl;
          pre_cnt <= `CSS_CNT_ZERO;
          brg_cnt <= `CSS_BRG_ZERO;
          if (start) begin
            shreg <= tx_buffer;
            bit_cnt <= `CSS_BIT_ZERO;
            half <= 1'b0;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (pre_tick) begin
            pre_cnt <= `CSS_CNT_ZERO;
            brg_cnt <= htick ? `CSS_BRG_ZERO : brg_cnt + 8'h01;
          end else begin
            pre_cnt <= pre_cnt + 5'h01;
          end
          if (!active) begin
            state <= ST_IDLE;
          end else if (htick && !half) begin
            // Leading edge: falling for polarity 0; data changes with it.
            ck <= !idle_lvl;
            dq <= out_bit ^ ch2_data_invert;
            half <= 1'b1;
          end else if (htick) begin
            // Trailing edge: rising for polarity 0; input is sampled.
            ck <= idle_lvl;
            half <= 1'b0;
            shreg <= next_sh;
            if (bit_cnt == `CSS_LAST_BIT) begin
              rx_word <= next_sh;
              xfer_done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Every pin is registered, so the pins trail the engine by one clock.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sdata_out <= 1'b1;
      sdata_oe <= 1'b0;
      sclk_out <= 1'b1;
      sclk_oe <= 1'b0;
      sclk2_out <= 1'b1;
      sclk2_oe <= 1'b0;
      rts_n_out <= 1'b1;
      err_n_out <= 1'b1;
      err_oe <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      // Open drain only pulls low; push-pull drives both levels.
      sdata_out <= output_type_select ? 1'b0 : dq;
      sdata_oe <= active && (!output_type_select || !dq);
      sclk_out <= output_type_select ? 1'b0 : ck;
      sclk_oe <= active && (!output_type_select || !ck);
      sclk2_out <= clock_pin_choice ? ck : idle_lvl;
      sclk2_oe <= active && multi_clock_output_select;
      rts_n_out <= (flow_control_disable || !handshake_source_select) ? 1'b1 :
        (rx_complete || !rx_enable);
      err_oe <= ch2_error_out_enable;
      err_n_out <= !overrun_flag;
      tx_irq <= intr_pending && (int_priority_level != `CSS_LVL_OFF);
    end
  end
endmodule

// ### pkg/css_consts.vh
// Constants for the clock-synchronous serial master: register map, fields, resets and dividers.
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH
// ----------------------------------------
// Register word indexes (byte address / 4)
// ----------------------------------------
`define CSS_IDX 5:2
`define CSS_A_TXB 4'h0
`define CSS_A_RXB 4'h1
`define CSS_A_BRG 4'h2
`define CSS_A_MODE 4'h3
`define CSS_A_CTL0 4'h4
`define CSS_A_CTL1 4'h5
`define CSS_A_SM1 4'h6
`define CSS_A_SM2 4'h7
`define CSS_A_SM3 4'h8
`define CSS_A_SM4 4'h9
`define CSS_A_UART01_SHARED_CONTROL 4'ha
`define CSS_A_TIC 4'hb
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSS_RST8 8'h00
`define CSS_RST32 32'h00000000
`define CSS_RST_CTL0 8'h00
`define CSS_RST_CTL1 8'h00
`define CSS_SYNC_LO 3'h0
`define CSS_SYNC_HI 3'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSS_MD_SMD 2:0
`define CSS_MD_CLOCK_SOURCE_SELECT 3
`define CSS_MD_IO_POLARITY_INVERT 7
`define CSS_C0_CNT 1:0
`define CSS_C0_HSS 2
`define CSS_C0_TXSE 3
`define CSS_C0_FCD 4
`define CSS_C0_OTS 5
`define CSS_C0_CPOL 6
`define CSS_C0_ORD 7
`define CSS_C1_TE 0
`define CSS_C1_TBE 1
`define CSS_C1_RE 2
`define CSS_C1_RC 3
`define CSS_C1_IRS 4
`define CSS_C1_RRM 5
`define CSS_C1_INV 6
`define CSS_C1_ERE 7
`define CSS_UC_PINSEL 4
`define CSS_UC_MULTI 5
`define CSS_UC_RSVD 7
`define CSS_UC_KEEP 8'h7f
`define CSS_TIC_LVL 2:0
`define CSS_TIC_IR 3
`define CSS_RXB_OER 8
`define CSS_HTRANS_NS 1
// ----------------------------------------
// Encodings and counts
// ----------------------------------------
`define CSS_SMD_CSIO 3'h1
`define CSS_LVL_OFF 3'h0
`define CSS_SRC_F1 2'h0
`define CSS_SRC_F8 2'h1
`define CSS_DIV_F1 5'h00
`define CSS_DIV_F8 5'h07
`define CSS_DIV_F32 5'h1f
`define CSS_LAST_BIT 3'h7
`define CSS_CNT_ZERO 5'h00
`define CSS_BRG_ZERO 8'h00
`define CSS_BIT_ZERO 3'h0
`endif

// ### sim/css_props.sv
// Concurrent checks on the serial master's pins.
`timescale 1ns/1ns
`include "css_consts.vh"
module css_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire sdata_in,
  input wire sdata_out,
  input wire sdata_oe,
  input wire sclk_out,
  input wire sclk_oe,
  input wire sclk2_out,
  input wire sclk2_oe,
  input wire cts_n_in,
  input wire rts_n_out,
  input wire err_n_out,
  input wire err_oe,
  input wire tx_irq
);
  reg ph;
  reg [3:0] pi;
  reg [7:0] sh [0:15];
  reg sq;
  reg [15:0] gap;
  wire [7:0] md = sh[`CSS_A_MODE];
  wire [7:0] c0 = sh[`CSS_A_CTL0];
  wire [7:0] c1 = sh[`CSS_A_CTL1];
  wire [7:0] uc = sh[`CSS_A_UART01_SHARED_CONTROL];
  wire lz = sh[`CSS_A_TIC][2:0] == 3'h0;
  wire act = md[2:0] == `CSS_SMD_CSIO && !md[3];
  wire [15:0] dv = c0[1:0] == 2'h0 ? 16'h1 : c0[1:0] == 2'h1 ? 16'h8 : 16'h20;
  wire [15:0] hl = ({8'h0, sh[`CSS_A_BRG]} + 16'h1) * dv;
  // Shadow copies of written registers and the clock half-period counter.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 1'b0;
      pi <= 4'h0;
      sq <= 1'b1;
      gap <= 16'h0;
      for (int k = 0; k < 16; k++) sh[k] <= 8'h00;
    end else begin
      ph <= hsel && htrans[1] && hready && hwrite;
      pi <= haddr[5:2];
      sq <= sclk_out;
      gap <= (sclk_out != sq) ? 16'h1 : gap + 16'h1;
      if (ph) sh[pi] <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_off;
    !act && !$past(act) |-> !sdata_oe && !sclk_oe;
  endproperty
  a_off: assert property (p_off) else $error("pins driven while inactive");
  property p_half;
    !c0[6] && $rose(sclk_out) |-> gap == hl;
  endproperty
  a_half: assert property (p_half) else $error("clock half period wrong");
  property p_edge;
    !c0[6] && $rose(sclk_out) |-> $stable(sdata_out);
  endproperty
  a_edge: assert property (p_edge) else $error("data moved on rising clock");
  property p_flow;
    c0[4] && $past(c0[4]) |-> rts_n_out;
  endproperty
  a_flow: assert property (p_flow) else $error("handshake active");
  property p_pp;
    act && $past(act) && !c0[5] && !$past(c0[5]) |-> sdata_oe && sclk_oe;
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull pins not driven");
  property p_err;
    !c1[7] && !$past(c1[7]) |-> !err_oe;
  endproperty
  a_err: assert property (p_err) else $error("error output driven");
  property p_clk2;
    !uc[5] && !$past(uc[5]) |-> !sclk2_oe;
  endproperty
  a_clk2: assert property (p_clk2) else $error("second clock pin driven");
  property p_lvl;
    lz && $past(lz) |-> !tx_irq;
  endproperty
  a_lvl: assert property (p_lvl) else $error("interrupt at level zero");
endmodule
bind css_master css_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .sclk_out(sclk_out),
  .sclk_oe(sclk_oe), .sclk2_out(sclk2_out), .sclk2_oe(sclk2_oe), .cts_n_in(cts_n_in), .rts_n_out(rts_n_out),
  .err_n_out(err_n_out), .err_oe(err_oe), .tx_irq(tx_irq));

// ### sim/css_eeprom.sv
// Serial memory stand-in: answers a byte MSB first and captures what it receives.
`timescale 1ns/1ns
module css_eeprom (
  input wire sclk,
  input wire en,
  input wire si,
  output logic so,
  input wire [7:0] reply,
  output logic [7:0] got
);
  logic [2:0] n = 3'h0;
  initial so = 1'b1;
  initial got = 8'h00;
  // Edges count only while the clock pin is driven, so the edge out of reset is ignored.
  always @(negedge sclk) begin
    if (en === 1'b1) begin
      so <= reply[3'h7 - n];
    end
  end
  // After the eighth bit the line no longer holds the last value.
  always @(posedge sclk) begin
    if (en === 1'b1) begin
      got <= {got[6:0], si};
      n <= n + 3'h1;
      if (n == 3'h7) begin
        so <= ~so;
      end
    end
  end
endmodule

// ### sim/css_master_bench.sv
// Self-checking bench for the serial master with a memory stand-in.
`timescale 1ns/1ns
`include "css_consts.vh"
module css_master_bench;
  logic hclk, hresetn, hsel, hwrite, cts_n_in;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] reply;
  wire [31:0] hrdata;
  wire [7:0] got;
  wire hreadyout, hresp, sdata_in, sdata_out, sdata_oe, sclk_out, sclk_oe, sclk2_out, sclk2_oe;
  wire rts_n_out, err_n_out, err_oe, tx_irq;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 32'ha973;
  css_master dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sclk2_out(sclk2_out), .sclk2_oe(sclk2_oe), .cts_n_in(cts_n_in), .rts_n_out(rts_n_out),
    .err_n_out(err_n_out), .err_oe(err_oe), .tx_irq(tx_irq));
  css_eeprom peer (.sclk(sclk_out), .en(sclk_oe), .si(sdata_out), .so(sdata_in), .reply(reply), .got(got));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  function automatic logic [7:0] g(input logic [7:0] x, input logic [1:0] m);
    logic [7:0] y;
    y = m[0] ? x : {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
    return m[1] ? ~y : y;
  endfunction
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // -------------------------------------
  // Bus cycles
  // -------------------------------------
  task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {26'h0, i, 2'h0};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
    @(posedge hclk);
  endtask
  task automatic poll(input logic [3:0] i, input int b, input logic v);
    logic [31:0] r;
    for (int k = 0; k < 1000; k++) begin
      bus(1'b0, i, 32'h0, r);
      if (r[b] === v) return;
    end
    chk("poll", {31'h0, v}, {31'h0, ~v});
  endtask
  // Mode bits: 0 bit order, 1 inversion, 2 slower count source and request at end of transfer.
  task automatic xfer8(input logic [7:0] tx, input logic [2:0] m);
    logic [31:0] r;
    reply = 8'($random(seed));
    wr(`CSS_A_CTL0, {24'h0, m[0], 6'h08, m[2]});
    wr(`CSS_A_CTL1, {24'h0, 1'b0, m[1], 1'b0, m[2], 4'h5});
    wr(`CSS_A_TXB, {24'h0, tx});
    poll(`CSS_A_TIC, 3, 1'b1);
    poll(`CSS_A_CTL1, 3, 1'b1);
    bus(1'b0, `CSS_A_RXB, 32'h0, r);
    chk("rx data", {24'h0, g(reply, m[1:0])}, r);
    chk("peer data", {24'h0, g(tx, m[1:0])}, {24'h0, got});
    wr(`CSS_A_TIC, 32'h0);
  endtask
  initial begin
    #2000000;
    error_cnt++;
    summarize;
  end
  initial begin
    logic [31:0] r;
    logic [7:0] v;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cts_n_in = 1'b1;
    reply = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 13; k++) begin
      bus(1'b0, k[3:0], 32'h0, r);
      chk("reset", k == 4 ? 8'h08 : k == 5 ? 8'h02 : 8'h00, r);
    end
    for (int k = 6; k < 13; k++) begin
      v = 8'($random(seed));
      wr(k[3:0], {24'h0, v});
      bus(1'b0, k[3:0], 32'h0, r);
      chk("readback", k < 10 ? v : k == 10 ? v & 8'h7f : k == 11 ? v & 8'h07 : 8'h00, r);
      wr(k[3:0], 32'h0);
    end
    wr(`CSS_A_BRG, 32'h7);
    wr(`CSS_A_MODE, 32'h1);
    for (int k = 0; k < 8; k++) begin
      v = 8'($random(seed));
      xfer8(v, k[2:0] ^ 3'h4);
    end
    wr(`CSS_A_TXB, 32'h5a);
    poll(`CSS_A_TIC, 3, 1'b1);
    wr(`CSS_A_TIC, 32'h0);
    poll(`CSS_A_CTL1, 1, 1'b1);
    wr(`CSS_A_TXB, 32'hc3);
    poll(`CSS_A_TIC, 3, 1'b1);
    poll(`CSS_A_CTL0, 3, 1'b1);
    poll(`CSS_A_CTL1, 3, 1'b1);
    bus(1'b0, `CSS_A_RXB, 32'h0, r);
    chk("overrun", {23'h0, 1'b1, g(reply, 2'h3)}, r);
    chk("error pin", 32'h0, {31'h0, err_n_out});
    wr(`CSS_A_CTL1, 32'h0);
    wr(`CSS_A_TXB, 32'h3c);
    for (int k = 0; k < 50; k++) bus(1'b0, `CSS_A_CTL1, 32'h0, r);
    chk("held", 32'h0, r);
    wr(`CSS_A_CTL1, 32'h1);
    poll(`CSS_A_CTL0, 3, 1'b0);
    poll(`CSS_A_CTL0, 3, 1'b1);
    bus(1'b0, `CSS_A_CTL1, 32'h0, r);
    chk("rx off", 32'h3, r);
    chk("peer data", 32'h3c, {24'h0, got});
    wr(`CSS_A_TIC, 32'h9);
    @(negedge hclk);
    chk("irq", 32'h1, {31'h0, tx_irq});
    @(posedge hclk);
    wr(`CSS_A_TIC, 32'h1);
    @(negedge hclk);
    chk("irq", 32'h0, {31'h0, tx_irq});
    summarize;
  end
endmodule
